// *** rtl/lts_pkg.sv ***
// constants and types for the layered trigger sequencer
// assumes a 50 MHz system clock and a classic wishbone slave port
`default_nettype none
package lts_pkg;
	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] LTS_CTRL_ADDR = 8'h00;
	localparam logic [7:0] LTS_SRC_ADDR = 8'h04;
	localparam logic [7:0] LTS_ARM_CNT_ADDR = 8'h08;
	localparam logic [7:0] LTS_SCAN_CNT_ADDR = 8'h0C;
	localparam logic [7:0] LTS_MEAS_CNT_ADDR = 8'h10;
	localparam logic [7:0] LTS_TIMER_ADDR = 8'h14;
	localparam logic [7:0] LTS_ACTION_ADDR = 8'h18;
	localparam logic [7:0] LTS_CMD_ADDR = 8'h1C;
	localparam logic [7:0] LTS_STATUS_ADDR = 8'h20;
	// control fields
	localparam int LTS_CTRL_ADV_BIT = 0;
	localparam int LTS_CTRL_CONT_BIT = 1;
	localparam int LTS_CTRL_SCAN_BIT = 2;
	localparam int LTS_CTRL_FUNC_BIT = 3;
	localparam int LTS_CTRL_AUTO_BIT = 4;
	// command bits (write only, self clearing)
	localparam int LTS_CMD_INIT_BIT = 0;
	localparam int LTS_CMD_BUS_MANUAL_TRIGGER_KEY_BIT = 1;
	localparam int LTS_CMD_ABORT_BIT = 2;
	// source field positions: arm [2:0], scan [6:4], measure [10:8]
	localparam int LTS_SRC_ARM_LSB = 0;
	localparam int LTS_SRC_SCAN_LSB = 4;
	localparam int LTS_SRC_MEAS_LSB = 8;
	// reset values
	localparam logic [4:0] LTS_CTRL_RESET = 5'h11;
	localparam logic [10:0] LTS_SRC_RESET = 11'h000;
	localparam logic [15:0] LTS_CNT_RESET = 16'h0001;
	localparam logic [15:0] LTS_CNT_INFINITE = 16'h0000;
	localparam logic [31:0] LTS_TIMER_RESET = 32'h0000C350;
	// device action timing: counts of clock cycles
	localparam int LTS_CLK_HZ = 50000000;
	localparam int LTS_SETTLE_US = 10;
	localparam logic [15:0] LTS_SETTLE_CYC = 16'(LTS_SETTLE_US * (LTS_CLK_HZ / 1000000));
	localparam logic [15:0] LTS_FUNC_CYC_RESET = 16'h0004;
	localparam logic [15:0] LTS_MEAS_CYC_RESET = 16'h0010;
	localparam logic [3:0] LTS_PULSE_CYC = 4'h4;
	// control sources
	typedef enum logic [2:0] {
		LTS_SRC_IMM = 3'h0,
		LTS_SRC_EXT = 3'h1,
		LTS_SRC_MAN = 3'h2,
		LTS_SRC_BUS = 3'h3,
		LTS_SRC_LINK = 3'h4,
		LTS_SRC_TIMER = 3'h5,
		LTS_SRC_HOLD = 3'h6
	} lts_src_t;
	// sequencer states
	typedef enum logic [3:0] {
		LTS_IDLE, LTS_ARM_WAIT, LTS_SCAN_WAIT, LTS_MEAS_WAIT,
		LTS_FUNC, LTS_OPEN, LTS_CLOSE, LTS_SETTLE, LTS_MEASURE,
		LTS_PULSE, LTS_NEXT
	} lts_state_t;
endpackage : lts_pkg
`default_nettype wire

// *** rtl/lts_sequencer.sv ***
// layered trigger sequencer with its wishbone register file
// assumes trigger inputs are single-cycle pulses synchronous to REF_CLK
//
// Functional notes
// R1: idle whenever outside every layer
// R2: start request leaves idle, sets armed
// R3: basic one layer, advanced three layers
// R4: each layer's source stalls until its event
// R5: immediate source is satisfied at once
// R6: external input trigger satisfies external source
// R7: manual key satisfies manual source
// R8: bus trigger command satisfies bus source
// R9: trigger link satisfies; not in basic
// R10: timer first pass immediate, then interval; the code never satisfies a timer source in the arm layer
// R11: hold never satisfies; not in basic
// R12: continuous basic skips source, back to back
// R13: action: function change, scan close, measure
// R14: open before close, settle inside action
// R15: output trigger pulse after every action
// R16: loop counters; infinite measure count stays
// R17: counter clears on return outward or idle
// R18: default advanced, auto start, immediate, infinite
// R19: repeat layer until count exhausted, then exit
//
// Our own choices: the register offsets and register access over Wishbone.
`default_nettype none
module lts_sequencer
	import lts_pkg::*;
(
	// clock, reset, enable
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic CE,
	// wishbone slave
	input wire logic WB_CYC,
	input wire logic WB_STB,
	input wire logic WB_WE,
	input wire logic [7:0] WB_ADR,
	input wire logic [3:0] WB_SEL,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK,
	// trigger inputs
	input wire logic EXTERNAL_TRIGGER_INPUT,
	input wire logic MANUAL_TRIGGER_KEY,
	input wire logic TRIGGER_LINK_SOURCE,
	// scanner and measurement control
	output logic ARMED,
	output logic OUTPUT_TRIGGER,
	output logic CHANNEL_CLOSED,
	output logic [7:0] CHANNEL,
	output logic MEASURING,
	input wire logic MEASURE_DONE
);
	// ****************************************
	// registers
	// ****************************************
	logic [4:0] ctrl;
	logic [10:0] src_sel;
	logic [15:0] arm_cnt_set;
	logic [15:0] scan_cnt_set;
	logic [15:0] meas_cnt_set;
	logic [31:0] timer_set;
	logic [7:0] chan_first;
	logic [7:0] chan_last;
	logic [15:0] func_cyc;
	logic func_pending;
	logic bus_manual_trigger_key;
	logic init_req;
	logic auto_done;
	lts_state_t state;
	lts_state_t next_state;
	logic [15:0] arm_cnt;
	logic [15:0] scan_cnt;
	logic [15:0] meas_cnt;
	logic [2:0] first_pass;
	logic [31:0] timer_cnt;
	logic [15:0] wait_cnt;
	logic [31:0] rd_data;
	logic overrun;
	logic chan_live;

	// ****************************************
	// bus decode
	// ****************************************
	wire logic wb_req = WB_CYC & WB_STB & ~WB_ACK;
	wire logic wb_wr = wb_req & WB_WE & (&WB_SEL);
	wire logic wr_ctrl = wb_wr & (WB_ADR == LTS_CTRL_ADDR);
	wire logic wr_src = wb_wr & (WB_ADR == LTS_SRC_ADDR);
	wire logic wr_arm = wb_wr & (WB_ADR == LTS_ARM_CNT_ADDR);
	wire logic wr_scan = wb_wr & (WB_ADR == LTS_SCAN_CNT_ADDR);
	wire logic wr_meas = wb_wr & (WB_ADR == LTS_MEAS_CNT_ADDR);
	wire logic wr_timer = wb_wr & (WB_ADR == LTS_TIMER_ADDR);
	wire logic wr_action = wb_wr & (WB_ADR == LTS_ACTION_ADDR);
	wire logic wr_cmd = wb_wr & (WB_ADR == LTS_CMD_ADDR);
	wire logic cmd_init = wr_cmd & WB_DAT_I[LTS_CMD_INIT_BIT];
	wire logic cmd_manual_trigger_key = wr_cmd & WB_DAT_I[LTS_CMD_BUS_MANUAL_TRIGGER_KEY_BIT];
	wire logic cmd_abort = wr_cmd & WB_DAT_I[LTS_CMD_ABORT_BIT];

	// read mux; unmapped addresses read zero
	always_comb begin
		if (WB_ADR == LTS_CTRL_ADDR) begin
			rd_data = {27'h0, ctrl};
		end else if (WB_ADR == LTS_SRC_ADDR) begin
			rd_data = {21'h0, src_sel};
		end else if (WB_ADR == LTS_ARM_CNT_ADDR) begin
			rd_data = {16'h0, arm_cnt_set};
		end else if (WB_ADR == LTS_SCAN_CNT_ADDR) begin
			rd_data = {16'h0, scan_cnt_set};
		end else if (WB_ADR == LTS_MEAS_CNT_ADDR) begin
			rd_data = {16'h0, meas_cnt_set};
		end else if (WB_ADR == LTS_TIMER_ADDR) begin
			rd_data = timer_set;
		end else if (WB_ADR == LTS_ACTION_ADDR) begin
			rd_data = {func_cyc, chan_last, chan_first};
		end else if (WB_ADR == LTS_STATUS_ADDR) begin
			rd_data = {meas_cnt, 7'h0, overrun, 3'h0, ARMED, 4'(state)};
		end else begin
			rd_data = 32'h0;
		end
	end

	// ack one cycle after request, dropped the next cycle
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			WB_ACK <= 1'b0;
			WB_DAT_O <= 32'h0;
		end else if (CE) begin
			WB_ACK <= wb_req;
			WB_DAT_O <= rd_data;
		end
	end

	// configuration registers
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			ctrl <= LTS_CTRL_RESET; // R18
			src_sel <= LTS_SRC_RESET;
			arm_cnt_set <= LTS_CNT_RESET;
			scan_cnt_set <= LTS_CNT_RESET;
			meas_cnt_set <= LTS_CNT_INFINITE;
			timer_set <= LTS_TIMER_RESET;
			chan_first <= 8'h00;
			chan_last <= 8'h00;
			func_cyc <= LTS_FUNC_CYC_RESET;
		end else if (CE) begin
			if (wr_ctrl) ctrl <= WB_DAT_I[4:0];
			if (wr_src) src_sel <= WB_DAT_I[10:0];
			if (wr_arm) arm_cnt_set <= WB_DAT_I[15:0];
			if (wr_scan) scan_cnt_set <= WB_DAT_I[15:0];
			if (wr_meas) meas_cnt_set <= WB_DAT_I[15:0];
			if (wr_timer) timer_set <= WB_DAT_I;
			if (wr_action) begin
				chan_first <= WB_DAT_I[7:0];
				chan_last <= WB_DAT_I[15:8];
				func_cyc <= WB_DAT_I[31:16];
			end
		end
	end

	// ****************************************
	// event detection
	// ****************************************
	wire logic adv = ctrl[LTS_CTRL_ADV_BIT];
	wire logic basic_cont = ~adv & ctrl[LTS_CTRL_CONT_BIT];
	wire logic in_wait = (state == LTS_ARM_WAIT) | (state == LTS_SCAN_WAIT) |
		(state == LTS_MEAS_WAIT);
	wire logic [1:0] layer = (state == LTS_ARM_WAIT) ? 2'd0 :
		(state == LTS_SCAN_WAIT) ? 2'd1 : 2'd2;
	// basic mode uses the measure layer's source alone
	wire logic [2:0] cur_src = (layer == 2'd0) ? src_sel[LTS_SRC_ARM_LSB +: 3] :
		(layer == 2'd1) ? src_sel[LTS_SRC_SCAN_LSB +: 3] :
		src_sel[LTS_SRC_MEAS_LSB +: 3]; // R3
	wire logic timer_hit = first_pass[layer] | (timer_cnt == 32'h0); // R10
	logic evt;
	always_comb begin
		case (lts_src_t'(cur_src))
			LTS_SRC_IMM: evt = 1'b1; // R5
			LTS_SRC_EXT: evt = EXTERNAL_TRIGGER_INPUT; // R6
			LTS_SRC_MAN: evt = MANUAL_TRIGGER_KEY; // R7
			LTS_SRC_BUS: evt = bus_manual_trigger_key; // R8
			LTS_SRC_LINK: evt = adv & TRIGGER_LINK_SOURCE; // R9
			LTS_SRC_TIMER: evt = (layer != 2'd0) & timer_hit; // R10
			LTS_SRC_HOLD: evt = 1'b0; // R11
			default: evt = 1'b0;
		endcase
	end
	wire logic evt_ok = in_wait & evt; // R4

	// loop count exhaustion; a zero setting means infinite
	wire logic meas_more = (meas_cnt_set == LTS_CNT_INFINITE) |
		(meas_cnt + 16'd1 < meas_cnt_set); // R16
	wire logic scan_more = (scan_cnt_set == LTS_CNT_INFINITE) |
		(scan_cnt + 16'd1 < scan_cnt_set);
	wire logic arm_more = (arm_cnt_set == LTS_CNT_INFINITE) |
		(arm_cnt + 16'd1 < arm_cnt_set);
	wire logic start = cmd_init | init_req | MANUAL_TRIGGER_KEY |
		(ctrl[LTS_CTRL_AUTO_BIT] & ~auto_done); // R2
	wire logic func_change = wr_ctrl & (WB_DAT_I[LTS_CTRL_FUNC_BIT] != ctrl[LTS_CTRL_FUNC_BIT]);

	// ****************************************
	// sequencer
	// ****************************************
	// next state selection
	always_comb begin
		next_state = state;
		case (state)
			LTS_IDLE: begin
				if (start) next_state = basic_cont ? LTS_FUNC :
					(adv ? LTS_ARM_WAIT : LTS_MEAS_WAIT); // R2
			end
			LTS_ARM_WAIT: if (evt_ok) next_state = LTS_SCAN_WAIT; // R4
			LTS_SCAN_WAIT: if (evt_ok) next_state = LTS_MEAS_WAIT; // R4
			LTS_MEAS_WAIT: if (evt_ok) next_state = LTS_FUNC; // R4
			LTS_FUNC: begin
				if (~func_pending | (wait_cnt == 16'h0)) begin
					next_state = ctrl[LTS_CTRL_SCAN_BIT] ? LTS_OPEN : LTS_MEASURE; // R13
				end
			end
			LTS_OPEN: next_state = LTS_CLOSE; // R14
			LTS_CLOSE: next_state = LTS_SETTLE; // R14
			LTS_SETTLE: if (wait_cnt == 16'h0) next_state = LTS_MEASURE; // R14
			LTS_MEASURE: if (MEASURE_DONE) next_state = LTS_PULSE; // R13
			LTS_PULSE: if (wait_cnt == 16'h0) next_state = LTS_NEXT; // R15
			LTS_NEXT: begin
				if (basic_cont) next_state = LTS_FUNC; // R12
				else if (~adv) next_state = LTS_IDLE; // R3
				else if (meas_more) next_state = LTS_MEAS_WAIT; // R19
				else if (scan_more) next_state = LTS_SCAN_WAIT; // R19
				else if (arm_more) next_state = LTS_ARM_WAIT; // R19
				else next_state = LTS_IDLE; // R19
			end
			default: next_state = LTS_IDLE;
		endcase
		if (cmd_abort) next_state = LTS_IDLE;
	end

	// state and armed flag
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			state <= LTS_IDLE; // R1
			ARMED <= 1'b0;
			auto_done <= 1'b0;
			init_req <= 1'b0;
		end else if (CE) begin
			state <= next_state;
			ARMED <= (next_state != LTS_IDLE); // R2
			if (state == LTS_IDLE && start) auto_done <= 1'b1;
			init_req <= cmd_init & (state != LTS_IDLE);
			if (wr_ctrl && WB_DAT_I[LTS_CTRL_AUTO_BIT]) auto_done <= 1'b0;
		end
	end

	// loop counters, cleared when leaving outward
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			arm_cnt <= 16'h0;
			scan_cnt <= 16'h0;
			meas_cnt <= 16'h0;
		end else if (CE) begin
			if (next_state == LTS_IDLE) begin
				arm_cnt <= 16'h0; // R17
				scan_cnt <= 16'h0;
				meas_cnt <= 16'h0;
			end else if (state == LTS_NEXT && !basic_cont) begin
				if (meas_more) begin
					meas_cnt <= meas_cnt + 16'd1; // R16
				end else if (scan_more) begin
					meas_cnt <= 16'h0; // R17
					scan_cnt <= scan_cnt + 16'd1;
				end else begin
					meas_cnt <= 16'h0; // R17
					scan_cnt <= 16'h0;
					arm_cnt <= arm_cnt + 16'd1;
				end
			end
		end
	end

	// timer: first pass flags per layer and free interval counter
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			first_pass <= 3'h7;
			timer_cnt <= LTS_TIMER_RESET;
		end else if (CE) begin
			if (state == LTS_IDLE) begin
				first_pass <= 3'h7; // R10
				timer_cnt <= timer_set - 32'd1;
			end else begin
				// reload one short so the period is exactly the interval
				timer_cnt <= (timer_cnt == 32'h0) ? timer_set - 32'd1 : timer_cnt - 32'd1;
				if (evt_ok) first_pass[layer] <= 1'b0;
			end
		end
	end

	// bus trigger and function change latches; set wins over clear
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			bus_manual_trigger_key <= 1'b0;
			func_pending <= 1'b0;
			overrun <= 1'b0;
		end else if (CE) begin
			if (cmd_manual_trigger_key) bus_manual_trigger_key <= 1'b1; // R8
			else if (evt_ok && cur_src == 3'(LTS_SRC_BUS)) bus_manual_trigger_key <= 1'b0;
			if (func_change) func_pending <= 1'b1; // R13
			else if (state == LTS_FUNC && next_state != LTS_FUNC) func_pending <= 1'b0;
			if (cmd_manual_trigger_key && bus_manual_trigger_key) overrun <= 1'b1;
			else if (wr_cmd) overrun <= 1'b0;
		end
	end

	// ****************************************
	// device action outputs
	// ****************************************
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			wait_cnt <= 16'h0;
			CHANNEL <= 8'h00;
			CHANNEL_CLOSED <= 1'b0;
			MEASURING <= 1'b0;
			OUTPUT_TRIGGER <= 1'b0;
			chan_live <= 1'b0;
		end else if (CE) begin
			if (next_state != state) begin
				case (next_state)
					LTS_FUNC: wait_cnt <= func_cyc;
					LTS_SETTLE: wait_cnt <= LTS_SETTLE_CYC; // R14
					LTS_PULSE: wait_cnt <= 16'(LTS_PULSE_CYC - 4'd1);
					default: wait_cnt <= 16'h0;
				endcase
			end else if (wait_cnt != 16'h0) begin
				wait_cnt <= wait_cnt - 16'd1;
			end
			if (next_state == LTS_OPEN) CHANNEL_CLOSED <= 1'b0; // R14
			if (next_state == LTS_CLOSE) begin
				CHANNEL_CLOSED <= 1'b1; // R13
				// first close of a run starts at the first channel
				CHANNEL <= (!chan_live || CHANNEL >= chan_last) ? chan_first :
					CHANNEL + 8'd1;
				chan_live <= 1'b1;
			end
			if (next_state == LTS_IDLE) begin
				CHANNEL_CLOSED <= 1'b0;
				chan_live <= 1'b0;
			end
			MEASURING <= (next_state == LTS_MEASURE);
			OUTPUT_TRIGGER <= (next_state == LTS_PULSE); // R15
		end
	end
endmodule : lts_sequencer
`default_nettype wire

// *** testbench/lts_chk.sv ***
// port assertions for the layered trigger sequencer
// assumes one clock domain and CE held high by the bench
`default_nettype none
module lts_chk
	import lts_pkg::*;
(
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST,
	// watched ports
	input wire logic CE,
	input wire logic WB_CYC,
	input wire logic WB_STB,
	input wire logic WB_ACK,
	input wire logic MANUAL_TRIGGER_KEY,
	input wire logic ARMED,
	input wire logic OUTPUT_TRIGGER,
	input wire logic CHANNEL_CLOSED,
	input wire logic [7:0] CHANNEL,
	input wire logic MEASURING,
	input wire logic MEASURE_DONE
);
	// ****************************************
	// helper and properties
	// ****************************************
	logic [9:0] closed_cnt;
	// cycles the relay has stayed closed, saturating
	always_ff @(posedge REF_CLK) begin
		if (RST || !CHANNEL_CLOSED)
			closed_cnt <= 10'h000;
		else if (closed_cnt != 10'h3FF)
			closed_cnt <= closed_cnt + 10'h001;
	end
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	sequence s_pulse;
		OUTPUT_TRIGGER [*4] ##1 !OUTPUT_TRIGGER;
	endsequence
	a_ack_next: assert property (CE && WB_CYC && WB_STB && !WB_ACK |=> WB_ACK)
		else $error("ack missing");
	a_ack_drop: assert property (WB_ACK |=> !WB_ACK)
		else $error("ack too long");
	a_auto_start: assert property ($fell(RST) |=> ARMED)
		else $error("no auto start");
	a_key_arms: assert property (!ARMED && MANUAL_TRIGGER_KEY |=> ARMED)
		else $error("key did not arm");
	a_meas_armed: assert property ($rose(MEASURING) |-> ARMED)
		else $error("measuring while idle");
	a_done_pulse: assert property (MEASURING && MEASURE_DONE |=>
		!MEASURING ##[0:2] $rose(OUTPUT_TRIGGER)) else $error("no pulse after action");
	a_pulse_len: assert property ($rose(OUTPUT_TRIGGER) |-> s_pulse)
		else $error("pulse length");
	a_break_make: assert property ($changed(CHANNEL) |-> !$past(CHANNEL_CLOSED))
		else $error("make before break");
	a_settle_time: assert property ($rose(MEASURING) && CHANNEL_CLOSED |->
		closed_cnt >= 10'h1F4) else $error("settle too short");
endmodule : lts_chk
bind lts_sequencer lts_chk u_chk (.REF_CLK(REF_CLK), .RST(RST), .CE(CE),
	.WB_CYC(WB_CYC), .WB_STB(WB_STB), .WB_ACK(WB_ACK), .ARMED(ARMED),
	.MANUAL_TRIGGER_KEY(MANUAL_TRIGGER_KEY), .OUTPUT_TRIGGER(OUTPUT_TRIGGER),
	.CHANNEL_CLOSED(CHANNEL_CLOSED), .CHANNEL(CHANNEL), .MEASURING(MEASURING),
	.MEASURE_DONE(MEASURE_DONE));
`default_nettype wire

// *** testbench/lts_partner.sv ***
// measurement engine and external scanner model
// assumes one clock and a synchronous active high reset
`default_nettype none
module lts_partner (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// device side
	input wire logic measuring,
	input wire logic out_manual_trigger_key,
	output logic done,
	// bench side
	input wire logic [7:0] lat,
	output logic [15:0] n_pulse
);
	// ****************************************
	// model
	// ****************************************
	logic [7:0] wait_cnt;
	logic last_manual_trigger_key;
	// one-cycle reply after lat+1 cycles of measuring
	always_ff @(posedge clk) begin
		if (rst || !measuring || done) begin
			wait_cnt <= 8'h00;
			done <= 1'b0;
		end else begin
			wait_cnt <= wait_cnt + 8'h01;
			done <= (wait_cnt >= lat);
		end
	end
	// scanner steps once per output pulse
	always_ff @(posedge clk) begin
		last_manual_trigger_key <= out_manual_trigger_key;
		if (rst)
			n_pulse <= 16'h0000;
		else if (out_manual_trigger_key && !last_manual_trigger_key)
			n_pulse <= n_pulse + 16'h0001;
	end
endmodule : lts_partner
`default_nettype wire

// *** testbench/lts_sequencer_tb.sv ***
// self-checking bench for the layered trigger sequencer
// assumes the bound checker and the partner model
`default_nettype none
module lts_sequencer_tb;
	import lts_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// harness
	// ****************************************
	logic clk, rst, cyc, stb, we, ack, ext, man, lnk, armd, otrig, closed, meas, done;
	logic [7:0] adr, lat, chan;
	logic [15:0] np;
	logic [31:0] wdat, dato, rdat;
	int bad_count, n_checks;
	lts_sequencer dut (.REF_CLK(clk), .RST(rst), .CE(1'b1), .WB_CYC(cyc), .WB_STB(stb),
		.WB_WE(we), .WB_ADR(adr), .WB_SEL(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(dato),
		.WB_ACK(ack), .EXTERNAL_TRIGGER_INPUT(ext), .MANUAL_TRIGGER_KEY(man),
		.TRIGGER_LINK_SOURCE(lnk), .ARMED(armd), .OUTPUT_TRIGGER(otrig),
		.CHANNEL_CLOSED(closed), .CHANNEL(chan), .MEASURING(meas), .MEASURE_DONE(done));
	lts_partner mdl (.clk(clk), .rst(rst), .measuring(meas), .out_manual_trigger_key(otrig),
		.done(done), .lat(lat), .n_pulse(np));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk); while (ack !== 1'b1 && ++n < 50);
		if (n >= 50) bad_count++;
		rdat = dato;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask : rd
	task automatic wait_np(input logic [15:0] exp, input int lim);
		for (int n = 0; np !== exp && n < lim; n++) @(posedge clk);
		chk({16'h0, np}, {16'h0, exp});
	endtask : wait_np
	task automatic idle_ok;
		for (int n = 0; armd !== 1'b0 && n < 100; n++) @(posedge clk);
		rd(LTS_STATUS_ADDR, 32'h0);
	endtask : idle_ok
	task automatic fire(input lts_src_t s);
		if (s == LTS_SRC_BUS) bus(1'b1, LTS_CMD_ADDR, 32'h2);
		@(posedge clk);
		ext <= (s == LTS_SRC_EXT);
		man <= (s == LTS_SRC_MAN);
		lnk <= (s == LTS_SRC_LINK);
		@(posedge clk);
		ext <= 1'b0;
		man <= 1'b0;
		lnk <= 1'b0;
	endtask : fire
	task automatic cfg(input logic [31:0] c, input lts_src_t s, input logic [15:0] m);
		bus(1'b1, LTS_CTRL_ADDR, c);
		bus(1'b1, LTS_SRC_ADDR, {21'h0, s, 8'h00});
		bus(1'b1, LTS_MEAS_CNT_ADDR, {16'h0, m});
	endtask : cfg
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_defaults;
		rd(LTS_CTRL_ADDR, 32'h11);
		rd(LTS_SRC_ADDR, 32'h0);
		rd(LTS_ARM_CNT_ADDR, 32'h1);
		rd(LTS_MEAS_CNT_ADDR, 32'h0);
		rd(LTS_TIMER_ADDR, 32'hC350);
		rd(8'h3C, 32'h0);
		wait_np(np + 16'h5, 1000);
		bus(1'b1, LTS_CMD_ADDR, 32'h4);
		idle_ok();
	endtask : t_defaults
	task automatic t_sources;
		lts_src_t s;
		logic [15:0] p;
		for (int i = 0; i < 7; i++) begin
			s = lts_src_t'(i);
			cfg(32'h1, s, 16'h1);
			p = np;
			bus(1'b1, LTS_CMD_ADDR, 32'h1);
			wait_np(p + 16'(s == LTS_SRC_IMM || s == LTS_SRC_TIMER), 40);
			fire(s);
			wait_np(p + 16'(s != LTS_SRC_HOLD), 100);
			if (s == LTS_SRC_HOLD) bus(1'b1, LTS_CMD_ADDR, 32'h4);
			idle_ok();
		end
	endtask : t_sources
	task automatic t_basic;
		logic [15:0] p;
		cfg(32'h0, LTS_SRC_LINK, 16'h1);
		p = np;
		bus(1'b1, LTS_CMD_ADDR, 32'h1);
		fire(LTS_SRC_LINK);
		wait_np(p, 60);
		bus(1'b1, LTS_CMD_ADDR, 32'h4);
		bus(1'b1, LTS_ARM_CNT_ADDR, 32'h2);
		cfg(32'h0, LTS_SRC_EXT, 16'h3);
		bus(1'b1, LTS_CMD_ADDR, 32'h1);
		fire(LTS_SRC_EXT);
		wait_np(p + 16'h1, 100);
		idle_ok();
		cfg(32'h2, LTS_SRC_HOLD, 16'h1);
		bus(1'b1, LTS_CMD_ADDR, 32'h1);
		wait_np(p + 16'h6, 400);
		bus(1'b1, LTS_CMD_ADDR, 32'h4);
		idle_ok();
	endtask : t_basic
	task automatic t_counts;
		logic [15:0] p;
		lat <= 8'h14;
		cfg(32'h1, LTS_SRC_IMM, 16'h2);
		bus(1'b1, LTS_SCAN_CNT_ADDR, 32'h3);
		for (int k = 0; k < 2; k++) begin
			p = np;
			fire(LTS_SRC_MAN);
			wait_np(p + 16'hC, 1500);
			idle_ok();
			chk({16'h0, np}, {16'h0, p + 16'hC});
		end
		lat <= 8'h02;
	endtask : t_counts
	task automatic t_timer;
		logic [15:0] p;
		time t;
		cfg(32'h1, LTS_SRC_TIMER, 16'h3);
		bus(1'b1, LTS_SCAN_CNT_ADDR, 32'h1);
		bus(1'b1, LTS_ARM_CNT_ADDR, 32'h1);
		bus(1'b1, LTS_TIMER_ADDR, 32'h64);
		p = np;
		bus(1'b1, LTS_CMD_ADDR, 32'h1);
		wait_np(p + 16'h2, 300);
		t = $time;
		wait_np(p + 16'h3, 300);
		chk(32'($time - t), 32'h7D0);
		idle_ok();
	endtask : t_timer
	task automatic t_scan;
		logic [15:0] p;
		cfg(32'hD, LTS_SRC_IMM, 16'h3);
		bus(1'b1, LTS_ACTION_ADDR, 32'h00040302);
		p = np;
		bus(1'b1, LTS_CMD_ADDR, 32'h1);
		wait_np(p + 16'h2, 2000);
		chk({24'h0, chan}, 32'h3);
		wait_np(p + 16'h3, 1000);
		idle_ok();
		chk({24'h0, chan}, 32'h2);
	endtask : t_scan
	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop
	// main sequence
	initial begin
		{rst, cyc, stb, we, ext, man, lnk} = 7'h40;
		{adr, wdat, lat} = 48'h02;
		bad_count = 0;
		n_checks = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_defaults();
		t_sources();
		t_basic();
		t_counts();
		t_timer();
		t_scan();
		report_and_stop();
	end
	// watchdog
	initial begin
		#1000000;
		bad_count++;
		report_and_stop();
	end
endmodule : lts_sequencer_tb
`default_nettype wire
